// *** core/burst_read_latency_wait_ctrl.sv ***
// The placing of the registers and register access over APB were chosen for this implementation.
module burst_read_latency_wait_ctrl (
	// apb slave
	input  wire logic                           pclk,
	input  wire logic                           presetn,
	input  wire logic                           clk_en,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [burst_pkg::PADDR_W-1:0]  paddr,
	input  wire logic [31:0]                    pwdata,
	output logic      [31:0]                    prdata,
	output logic                                pready,
	output logic                                pslverr,
	// memory pins
	input  wire logic                           flash_clk,
	input  wire logic                           ce_n,
	input  wire logic                           address_valid_strobe_n,
	input  wire logic [15:0]                    addr_pin,
	output logic                                wait_o,
	output logic                                wait_oe,
	output logic      [15:0]                    dq_o,
	output logic                                dq_oe,
	// array side
	output logic      [15:0]                    array_word_addr,
	input  wire logic [15:0]                    array_rdata
);
	import burst_pkg::*;

	// ==========================================================
	// pin sampling and edge detection
	sync_bus_if #(.W(SYNC_W)) sb ();

	logic        clk_s;
	logic        ce_n_s;
	logic        adv_n_s;
	logic [15:0] addr_s;
	logic        clk_d_reg;
	logic        adv_d_reg;

	assign sb.raw = {flash_clk, ce_n, address_valid_strobe_n, addr_pin};
	assign sb.en  = clk_en;

	pin_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.bus     (sb)
	);

	assign {clk_s, ce_n_s, adv_n_s, addr_s} = sb.sync;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_d_reg <= 1'b1;
			adv_d_reg <= 1'b1;
		end else if (clk_en) begin
			clk_d_reg <= clk_s;
			adv_d_reg <= adv_n_s;
		end
	end

	// ==========================================================
	// registers
	logic [15:0] cfg_reg;
	logic        read_array_reg;
	logic [31:0] prdata_reg;

	logic       cfg_rm;
	logic [2:0] cfg_lc;
	logic       cfg_pol;
	logic       cfg_hold;
	logic       cfg_early;
	logic       cfg_rise;
	logic       cfg_nowrap;
	logic [2:0] cfg_bl;

	assign cfg_rm     = cfg_reg[RM_BIT];
	assign cfg_lc     = cfg_reg[LC_MSB:LC_LSB];
	assign cfg_pol    = cfg_reg[POL_BIT];
	assign cfg_hold   = cfg_reg[HOLD_BIT];
	assign cfg_early  = cfg_reg[TIMING_BIT];
	assign cfg_rise   = cfg_reg[EDGE_BIT];
	assign cfg_nowrap = cfg_reg[NOWRAP_BIT];
	assign cfg_bl     = cfg_reg[BL_MSB:BL_LSB];

	logic clk_rise;
	logic clk_fall;
	logic act_edge;
	logic adv_rise;
	logic adv_fall;
	logic ce_act;

	assign clk_rise = clk_s & ~clk_d_reg;
	assign clk_fall = ~clk_s & clk_d_reg;
	assign act_edge = clk_en & (cfg_rise ? clk_rise : clk_fall);
	assign adv_rise = clk_en & adv_n_s & ~adv_d_reg;
	assign adv_fall = clk_en & ~adv_n_s & adv_d_reg;
	assign ce_act   = ~ce_n_s;

	// ==========================================================
	// burst sequencing
	burst_state_t state_reg;
	logic         taken_reg;
	logic         misal_reg;
	logic         crossed_reg;
	logic [2:0]   lat_cnt_reg;
	logic         hold_cnt_reg;
	logic         stall_cnt_reg;
	logic [3:0]   words_left_reg;
	logic [15:0]  word_addr_reg;
	logic [15:0]  dq_reg;

	logic        sync_array;
	logic        bl_cont;
	logic        latch;
	logic        cross_ok;
	logic        cross_now;
	logic        at_end;
	logic        early;
	logic        present;
	logic [15:0] group_mask;
	logic [15:0] addr_inc;
	logic [15:0] addr_next;

	assign sync_array = ~cfg_rm & read_array_reg;
	assign bl_cont    = (cfg_bl == BL_CONT);
	assign latch      = ~taken_reg & ce_act & (adv_rise | (act_edge & ~adv_n_s));
	// continuous bursts ignore the wrap bit
	assign cross_ok   = misal_reg & (bl_cont ? ~crossed_reg : cfg_nowrap);
	assign cross_now  = cross_ok & (word_addr_reg[3:0] == 4'h0);
	assign at_end     = ~bl_cont & (words_left_reg == 4'h0);
	assign early      = cfg_early & (state_reg == ST_DATA) & cross_now & ~at_end;
	assign group_mask = (cfg_bl == BL_8) ? GROUP8_MASK : GROUP4_MASK;
	assign addr_inc   = word_addr_reg + 16'h0001;
	assign addr_next  = (~cfg_nowrap & ~bl_cont) ?
		((word_addr_reg & ~group_mask) | (addr_inc & group_mask)) : addr_inc;

	assign present = act_edge & (
		((state_reg == ST_LATENCY) & (lat_cnt_reg == 3'h0)) |
		((state_reg == ST_DATA) & ~hold_cnt_reg & ~at_end & ~cross_now) |
		((state_reg == ST_STALL) & ~stall_cnt_reg));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			taken_reg <= 1'b0;
		end else if (clk_en) begin
			if (latch) begin
				taken_reg <= 1'b1;
			end else if (adv_fall | ~ce_act) begin
				taken_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
		end else if (clk_en) begin
			if (~ce_act | ~sync_array) begin
				state_reg <= ST_IDLE;
			end else if (latch) begin
				state_reg <= ST_LATENCY;
			end else if (act_edge) begin
				unique case (state_reg)
					ST_IDLE: begin
					end
					ST_LATENCY: begin
						if (lat_cnt_reg == 3'h0) begin
							state_reg <= ST_DATA;
						end
					end
					ST_DATA: begin
						if (!hold_cnt_reg && at_end) begin
							state_reg <= ST_DONE;
						end else if (!hold_cnt_reg && cross_now) begin
							state_reg <= ST_STALL;
						end
					end
					ST_STALL: begin
						if (!stall_cnt_reg) begin
							state_reg <= ST_DATA;
						end
					end
					ST_DONE: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lat_cnt_reg    <= 3'h0;
			hold_cnt_reg   <= 1'b0;
			stall_cnt_reg  <= 1'b0;
			words_left_reg <= 4'h0;
			word_addr_reg  <= 16'h0000;
			misal_reg      <= 1'b0;
			crossed_reg    <= 1'b0;
			dq_reg         <= 16'h0000;
		end else if (clk_en) begin
			if (latch) begin
				lat_cnt_reg    <= cfg_lc;
				word_addr_reg  <= addr_s;
				misal_reg      <= (addr_s[1:0] != 2'h0);
				crossed_reg    <= 1'b0;
				words_left_reg <= (cfg_bl == BL_8) ? WORDS_8 : WORDS_4;
			end else if (present) begin
				dq_reg         <= array_rdata;
				word_addr_reg  <= addr_next;
				hold_cnt_reg   <= cfg_hold;
				if (!bl_cont) begin
					words_left_reg <= words_left_reg - 4'h1;
				end
			end else if (act_edge) begin
				if (state_reg == ST_LATENCY) begin
					lat_cnt_reg <= lat_cnt_reg - 3'h1;
				end
				if (state_reg == ST_DATA && hold_cnt_reg) begin
					hold_cnt_reg <= 1'b0;
				end
				// the row stall lasts one data slot
				if (state_reg == ST_DATA && !hold_cnt_reg && cross_now && !at_end) begin
					stall_cnt_reg <= cfg_hold;
					crossed_reg   <= 1'b1;
				end
				if (state_reg == ST_STALL && stall_cnt_reg) begin
					stall_cnt_reg <= 1'b0;
				end
			end
		end
	end

	// ==========================================================
	// pin outputs
	logic wait_asserted;
	logic wait_o_reg;
	logic wait_oe_reg;
	logic dq_oe_reg;

	// outside sync read-array the pin carries no validity
	assign wait_asserted = sync_array ? ~((state_reg == ST_DATA) & ~early) : 1'b1;

	// wait lags the data by one pclk, so data settles before wait clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_o_reg  <= 1'b0;
			wait_oe_reg <= 1'b0;
			dq_oe_reg   <= 1'b0;
		end else if (clk_en) begin
			wait_o_reg  <= cfg_pol ? wait_asserted : ~wait_asserted;
			wait_oe_reg <= ce_act;
			dq_oe_reg   <= ce_act & (state_reg == ST_DATA);
		end
	end

	assign wait_o          = wait_o_reg;
	assign wait_oe         = wait_oe_reg;
	assign dq_o            = dq_reg;
	assign dq_oe           = dq_oe_reg;
	assign array_word_addr = word_addr_reg;

	// ==========================================================
	// apb slave
	logic mapped;
	logic wr;

	assign mapped  = (paddr == OFS_CONFIG) | (paddr == OFS_CONTROL) | (paddr == OFS_STATUS);
	assign wr      = psel & penable & pwrite & clk_en & mapped;
	assign pready  = clk_en;
	assign pslverr = psel & penable & ~mapped;
	assign prdata  = prdata_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg        <= CFG_RST;
			read_array_reg <= RA_RST;
		end else if (wr) begin
			if (paddr == OFS_CONFIG) begin
				cfg_reg <= pwdata[CFG_W-1:0];
			end
			if (paddr == OFS_CONTROL) begin
				read_array_reg <= pwdata[RA_BIT];
			end
		end
	end

	// read data is captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h00000000;
		end else if (clk_en && psel && !penable) begin
			if (paddr == OFS_CONFIG) begin
				prdata_reg <= {16'h0000, cfg_reg};
			end else if (paddr == OFS_CONTROL) begin
				prdata_reg <= {31'h00000000, read_array_reg};
			end else if (paddr == OFS_STATUS) begin
				prdata_reg <= {24'h000000, crossed_reg, wait_asserted, state_reg == ST_DATA,
					state_reg != ST_IDLE, word_addr_reg[3:0]};
			end else begin
				prdata_reg <= 32'h00000000;
			end
		end
	end

	// ==========================================================
	// checks
	logic [3:0] edges_seen_reg;
	logic       hold_edges_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edges_seen_reg <= 4'h0;
			hold_edges_reg <= 1'b0;
		end else if (clk_en) begin
			if (latch) begin
				edges_seen_reg <= 4'h0;
			end else if (act_edge && state_reg == ST_LATENCY) begin
				edges_seen_reg <= edges_seen_reg + 4'h1;
			end
			if (present) begin
				hold_edges_reg <= 1'b0;
			end else if (act_edge) begin
				hold_edges_reg <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence enter_stall_s;
		act_edge && state_reg == ST_DATA && !hold_cnt_reg && cross_now && !at_end && ce_act && sync_array && !latch;
	endsequence

	first_latency_a: assert property ((present && state_reg == ST_LATENCY) |-> edges_seen_reg == {1'b0, cfg_lc})
		else $error("first word not after latency count");
	word_hold_a: assert property ((present && state_reg == ST_DATA) |-> hold_edges_reg == cfg_hold)
		else $error("burst word hold length wrong");
	row_stall_a: assert property (enter_stall_s |=> state_reg == ST_STALL ##1 $past(crossed_reg))
		else $error("row crossing stall missing");
	stall_cause_a: assert property ($rose(state_reg == ST_STALL) |-> misal_reg && (bl_cont || cfg_nowrap))
		else $error("stall without misaligned crossing");
	wait_float_a: assert property (!ce_act |=> !wait_oe)
		else $error("wait driven while chip disabled");
	valid_wait_a: assert property ((state_reg == ST_DATA && sync_array && !early) |=> wait_o == !$past(cfg_pol))
		else $error("wait asserted over valid data");
	async_wait_a: assert property ((cfg_rm || !read_array_reg) |=> wait_o == $past(cfg_pol))
		else $error("wait not asserted outside sync array read");
	early_wait_a: assert property (early |=> wait_o == $past(cfg_pol))
		else $error("early wait not asserted");
	edge_pick_a: assert property (act_edge |-> clk_s == cfg_rise && clk_s != clk_d_reg)
		else $error("wrong link clock edge used");
	latch_once_a: assert property (latch |=> taken_reg && word_addr_reg == $past(addr_s))
		else $error("burst address not latched");

endmodule

// *** core/burst_pkg.sv ***
package burst_pkg;

	// ==========================================================
	// register bus
	localparam int          PADDR_W      = 8;
	localparam logic [7:0]  OFS_CONFIG   = 8'h00;
	localparam logic [7:0]  OFS_CONTROL  = 8'h04;
	localparam logic [7:0]  OFS_STATUS   = 8'h08;

	// ==========================================================
	// burst_config_word layout and reset value
	localparam int           CFG_W         = 16;
	localparam logic [15:0]  CFG_RST       = 16'hFFFF;
	localparam int           RM_BIT        = 15;
	localparam int           LC_MSB        = 13;
	localparam int           LC_LSB        = 11;
	localparam int           POL_BIT       = 10;
	localparam int           HOLD_BIT      = 9;
	localparam int           TIMING_BIT    = 8;
	localparam int           EDGE_BIT      = 6;
	localparam int           NOWRAP_BIT    = 3;
	localparam int           BL_MSB        = 2;
	localparam int           BL_LSB        = 0;
	localparam logic [2:0]   BL_8          = 3'h2;
	localparam logic [2:0]   BL_CONT       = 3'h7;
	localparam logic [3:0]   WORDS_4       = 4'h4;
	localparam logic [3:0]   WORDS_8       = 4'h8;
	localparam logic [15:0]  GROUP4_MASK   = 16'h0003;
	localparam logic [15:0]  GROUP8_MASK   = 16'h0007;

	// ==========================================================
	// control register: partition in read-array state
	localparam int           RA_BIT        = 0;
	localparam logic         RA_RST        = 1'b1;

	// ==========================================================
	// pin synchroniser: {link clock, chip enable, strobe, address}
	localparam int             SYNC_W      = 19;
	localparam logic [18:0]    SYNC_RST    = 19'h7FFFF;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LATENCY,
		ST_DATA,
		ST_STALL,
		ST_DONE
	} burst_state_t;

endpackage

// *** core/sync_bus_if.sv ***
interface sync_bus_if #(parameter int W = 19);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	logic         en;
	modport src    (output raw, output en, input sync);
	modport syncer (input raw, input en, output sync);
endinterface

// *** core/pin_sync.sv ***
module pin_sync #(
	parameter int         W   = 19,
	parameter logic [W-1:0] RST = '1
) (
	// clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// pins in, sampled out
	sync_bus_if.syncer bus
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= RST;
			sync_reg <= RST;
		end else if (bus.en) begin
			meta_reg <= bus.raw;
			sync_reg <= meta_reg;
		end
	end

	assign bus.sync = sync_reg;
endmodule

// *** bench/flash_host_model.sv ***
module flash_host_model (
	// link pins
	output logic        flash_clk,
	output logic        ce_n,
	output logic        address_valid_strobe_n,
	output logic [15:0] addr_pin,
	// active edges since frame start
	output int          edge_cnt
);
	timeunit 1ns;
	timeprecision 100ps;

	// raise the strobe before the first link edge
	logic adv_first = 1'b0;

	initial begin
		flash_clk = 1'b0;
		ce_n = 1'b1;
		address_valid_strobe_n = 1'b1;
		addr_pin = 16'h0000;
		edge_cnt = 0;
	end

	// ==========================================================
	// one chip-enable frame
	// wait is ignored here in every read, burst array reads included
	// the clock stands still between frames, the address pins show junk
	task automatic frame(input logic [15:0] a, input logic rise, input int periods);
		flash_clk = rise ? 1'b0 : 1'b1;
		#5;
		ce_n = 1'b0;
		addr_pin = a;
		address_valid_strobe_n = 1'b0;
		edge_cnt = 0;
		if (adv_first) #20 address_valid_strobe_n = 1'b1;
		repeat (periods) begin
			#40 flash_clk = ~flash_clk;
			edge_cnt++;
			if (edge_cnt == 1) begin
				// strobe rises after the latch edge
				#20 address_valid_strobe_n = 1'b1;
				#20;
			end else begin
				#40;
			end
			flash_clk = ~flash_clk;
		end
		#40 ce_n = 1'b1;
		addr_pin = ~a;
	endtask
endmodule

// *** bench/burst_read_latency_wait_ctrl_tb_top.sv ***
module burst_read_latency_wait_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import burst_pkg::*;

	logic              pclk    = 1'b0;
	logic              presetn = 1'b0;
	logic              psel    = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite  = 1'b0;
	logic [7:0]        paddr   = 8'h00;
	logic [31:0]       pwdata  = 32'h0;
	logic [31:0]       prdata;
	logic              pready, pslverr, flash_clk, ce_n, address_valid_strobe_n;
	logic              wait_o, wait_oe, dq_oe;
	logic [15:0]       addr_pin, dq_o, array_word_addr;
	wire logic [15:0]  array_rdata = array_word_addr ^ 16'h5A3C;
	int                edge_cnt, stalls, oe_cyc, first, lim;
	int                error_cnt   = 0;
	int                comparisons = 0;
	logic              mon = 1'b0;
	logic              pol_c, ew, poe, deas, oes;
	logic [15:0]       pdq;
	logic [15:0]       words[$];

	always #5 pclk = ~pclk;

	burst_read_latency_wait_ctrl u_burst_read_latency_wait_ctrl (
		.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_clk(flash_clk), .ce_n(ce_n),
		.address_valid_strobe_n(address_valid_strobe_n), .addr_pin(addr_pin), .wait_o(wait_o),
		.wait_oe(wait_oe), .dq_o(dq_o), .dq_oe(dq_oe), .array_word_addr(array_word_addr),
		.array_rdata(array_rdata));

	flash_host_model u_flash_host_model (
		.flash_clk(flash_clk), .ce_n(ce_n), .address_valid_strobe_n(address_valid_strobe_n),
		.addr_pin(addr_pin), .edge_cnt(edge_cnt));

	// ==========================================================
	// report
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask

	initial begin
		#500000;
		error_cnt++;
		$display("watchdog expired");
		results;
	end

	// ==========================================================
	// apb master
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	// ==========================================================
	// expectations
	function automatic logic [15:0] exp_addr(input logic [15:0] s, input int i, input int len, input logic c,
		input logic nw);
		logic [15:0] m;
		m = 16'(len - 1);
		if (c || nw)
			return s + 16'(i);
		return (s & ~m) | ((s + 16'(i)) & m);
	endfunction

	function automatic int exp_stalls(input logic [15:0] s, input int len, input logic c, input logic nw);
		int k;
		k = 0;
		if (s[1:0] == 2'b00 || !(c || nw))
			return 0;
		if (c)
			return 1;
		for (int i = 1; i < len; i++)
			if (((s + 16'(i)) & 16'h000F) == 16'h0000)
				k++;
		return k;
	endfunction

	// ==========================================================
	// pin monitor, sampled where outputs are settled
	always @(negedge pclk) begin
		if (mon) begin
			if (dq_oe === 1'b1 && (poe !== 1'b1 || dq_o !== pdq)) begin
				// a gap in the word stream inside the burst is a row stall
				if (words.size() == 0)
					first = edge_cnt;
				else if (poe !== 1'b1 && words.size() < lim)
					stalls++;
				words.push_back(dq_o);
			end
			if (dq_oe === 1'b1)
				oe_cyc++;
			// only the enable-qualified level counts, so a shared line is safe
			if (wait_oe === 1'b1) begin
				oes = 1'b1;
				if (wait_o !== pol_c) begin
					deas = 1'b1;
					chk("dq_oe at valid", 1, dq_oe);
				end else if (dq_oe === 1'b1 && words.size() < lim) begin
					ew = 1'b1;
				end
			end
			poe = dq_oe;
			pdq = dq_o;
		end
	end

	// ==========================================================
	// one configured burst frame
	task run(input logic rm, input logic ra, input logic [2:0] lc, input logic pol, input logic hold,
		input logic tim, input logic edg, input logic nw, input logic [2:0] bl, input logic [15:0] st, input int n);
		logic [15:0] cfg;
		int len, ex;
		logic [31:0] rd;
		logic er;
		cfg = {rm, 1'b0, lc, pol, hold, tim, 1'b1, edg, 2'b00, nw, bl};
		len = (bl == BL_CONT) ? n : ((bl == BL_8) ? 8 : 4);
		wr(OFS_CONFIG, {16'h0000, cfg});
		wr(OFS_CONTROL, {31'h0, ra});
		apb(1'b0, OFS_CONFIG, 32'h0, rd, er);
		chk("config readback", {16'h0000, cfg}, rd);
		words.delete();
		stalls = 0;
		oe_cyc = 0;
		first = 0;
		deas = 1'b0;
		oes = 1'b0;
		ew = 1'b0;
		pol_c = pol;
		lim = len;
		mon = 1'b1;
		u_flash_host_model.frame(st, edg, 32'(lc) + (len + 4) * (32'(hold) + 1) + 6);
		mon = 1'b0;
		if (rm || !ra) begin
			chk("word count", 0, words.size());
			chk("wait deasserted", 0, deas);
			chk("wait driven", 1, oes);
		end else begin
			chk("word count", len, (bl == BL_CONT && words.size() > len) ? len : words.size());
			for (int i = 0; i < len && i < words.size(); i++)
				chk("word", exp_addr(st, i, len, bl == BL_CONT, nw) ^ 16'h5A3C, words[i]);
			chk("first edge", lc + 2 - u_flash_host_model.adv_first, first);
			ex = exp_stalls(st, len, bl == BL_CONT, nw);
			chk("stalls", ex, stalls);
			chk("early wait", tim && ex > 0, ew);
			if (ex == 0 && bl != BL_CONT)
				chk("hold", 1, oe_cyc >= len * (hold + 1) * 8 - 3 && oe_cyc <= len * (hold + 1) * 8 + 3);
		end
		repeat (6) @(posedge pclk);
		chk("wait float", 0, wait_oe);
		$display("frame done start %0h config %0h", st, cfg);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		logic [31:0] r;
		logic e;
		void'($urandom(32'h4713));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFS_CONFIG, 32'h0, r, e);
		chk("config reset", {16'h0000, CFG_RST}, r);
		apb(1'b0, OFS_CONTROL, 32'h0, r, e);
		chk("control reset", 32'h1, r);
		apb(1'b0, OFS_STATUS, 32'h0, r, e);
		chk("status reset", 32'h40, r);
		apb(1'b0, 8'h0C, 32'h0, r, e);
		chk("unmapped error", 1, e);
		chk("unmapped data", 0, r);
		$display("register test done");
		run(1'b1, 1'b1, 3'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 16'h0010, 4);
		run(1'b0, 1'b0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 16'h0010, 4);
		run(1'b0, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 16'h0020, 4);
		run(1'b0, 1'b1, 3'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, BL_8, 16'h000D, 8);
		run(1'b0, 1'b1, 3'h5, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h1, 16'h002E, 4);
		run(1'b0, 1'b1, 3'h4, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, BL_CONT, 16'h001D, 20);
		run(1'b0, 1'b1, 3'h2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, BL_8, 16'h0005, 8);
		run(1'b0, 1'b1, 3'h3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, BL_CONT, 16'h0040, 10);
		// latency codes stay within the legal range
		// strobe released before the first edge: the latch comes from its rise
		u_flash_host_model.adv_first = 1'b1;
		run(1'b0, 1'b1, 3'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h1, 16'h0024, 4);
		repeat (6) begin
			u_flash_host_model.adv_first = 1'($urandom);
			run(1'b0, 1'b1, 3'(2 + $urandom % 4), 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom),
				1'($urandom), $urandom % 2 ? BL_8 : 3'h1, 16'($urandom), 4);
		end
		results;
	end
endmodule
